// >>> core/agcdb_pkg.sv
// Constants, field layout and carrier types of the gain and gate debounce bank
// Functional notes
// R1: Left applied gain reads back, signed half-dB
// R2: Right applied gain reads back, signed half-dB
// R3: Gain readbacks reset to zero, 0 dB
// R4: Left noise debounce codes 0-7 span 0-32 ms
// R5: Noise codes eight up give 64 ms steps
// R6: Left signal debounce field, 0 to 32 ms
// R7: Right noise debounce field, same encoding
// R8: Right signal debounce field, same encoding
// R9: Double rate audio changes debounce step timing
// R10: Debounce fields reset to zero, read/write
// R11: Detection status one while below noise threshold
// R12: Saturation flag while applied gain equals maximum
// R13: Zero noise threshold disables detection and debounce
// R14: State changes after condition persists debounce time
package agcdb_pkg;

  // Register indexes; byte address is four times the index
  localparam logic [7:0] IDX_LEFT_GAIN = 8'h20;
  localparam logic [7:0] IDX_RIGHT_GAIN = 8'h21;
  localparam logic [7:0] IDX_LEFT_DEB = 8'h22;
  localparam logic [7:0] IDX_RIGHT_DEB = 8'h23;
  localparam logic [7:0] IDX_CTRL = 8'h30;
  localparam logic [7:0] IDX_FLAGS = 8'h31;
  localparam logic [7:0] IDX_IRQ_STAT = 8'h32;
  localparam logic [7:0] IDX_IRQ_MASK = 8'h33;

  // Bus widths
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;

  // Debounce register fields
  localparam int NOISE_MSB = 7;
  localparam int NOISE_LSB = 3;
  localparam int SIG_MSB = 2;
  localparam int SIG_LSB = 0;

  // Control and flag bit positions
  localparam int CTRL_DBL_RATE_BIT = 0;
  localparam int FLAG_LDET = 5;
  localparam int FLAG_LSAT = 4;
  localparam int FLAG_RDET = 1;
  localparam int FLAG_RSAT = 0;

  // Interrupt status and mask layout
  localparam int IRQ_W = 4;
  localparam int IRQ_LDET = 0;
  localparam int IRQ_RDET = 1;
  localparam int IRQ_LSAT = 2;
  localparam int IRQ_RSAT = 3;

  // Reset values
  localparam logic [7:0] GAIN_RST = 8'h00;
  localparam logic [7:0] DEB_RST = 8'h00;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [IRQ_W-1:0] IRQ_RST = 4'h0;

  // Highest applied gain code, 59.5 dB
  localparam logic [6:0] GAIN_MAX_CODE = 7'h77;

  // Debounce timing: one step is half a millisecond
  localparam int CLK_PERIOD_NS = 50;
  localparam int DEB_STEP_NS = 500000;
  localparam int DEB_STEP_CYCLES = DEB_STEP_NS / CLK_PERIOD_NS;
  localparam int LONG_STEP_TICKS = 128;
  localparam logic [4:0] SHORT_CODES = 5'h08;
  localparam logic [4:0] LONG_BASE = 5'h07;
  localparam int CNT_W = 12;
  localparam int PRE_W = 14;

  // APB request from the master
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [DATA_W-1:0] pwdata;
  } agcdb_apb_req_type;

  // APB answer to the master
  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [DATA_W-1:0] prdata;
  } agcdb_apb_rsp_type;

  // Per channel state coming from the level control engine
  typedef struct packed {
    logic [7:0] gain;
    logic [6:0] max_gain;
    logic [4:0] noise_thr;
    logic below_thr;
  } agcdb_chan_type;

  // Register select
  typedef enum logic [3:0] {
    SEL_NONE = 4'b0000,
    SEL_LGAIN = 4'b0001,
    SEL_RGAIN = 4'b0010,
    SEL_LDEB = 4'b0011,
    SEL_RDEB = 4'b0100,
    SEL_CTRL = 4'b0101,
    SEL_FLAGS = 4'b0110,
    SEL_ISTAT = 4'b0111,
    SEL_IMASK = 4'b1000
  } agcdb_sel_type;

endpackage : agcdb_pkg

// >>> core/agcdb_top.sv
// Gain readback and noise gate debounce register bank with APB slave
//
// Chosen here: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module agcdb_top #(
  parameter int STEP_CYCLES = agcdb_pkg::DEB_STEP_CYCLES
) (
  input wire logic CLK_SYS_IN,
  input wire logic RST_IN,
  input wire agcdb_pkg::agcdb_apb_req_type APB_REQ_IN,
  input wire agcdb_pkg::agcdb_chan_type LEFT_CHAN_IN,
  input wire agcdb_pkg::agcdb_chan_type RIGHT_CHAN_IN,
  output agcdb_pkg::agcdb_apb_rsp_type APB_RSP_OUT,
  output logic [1:0] GATE_STATE_OUT,
  output logic IRQ_OUT
);
  import agcdb_pkg::*;

  // Step count per rate mode: half a millisecond, quarter at double rate
  localparam logic [PRE_W-1:0] STEP_FULL = PRE_W'(STEP_CYCLES);
  localparam logic [PRE_W-1:0] STEP_HALF = PRE_W'(STEP_CYCLES / 2);

  // Debounce code to number of half millisecond steps
  function automatic logic [CNT_W-1:0] debounce_ticks(
    input logic [4:0] code
  );
    logic [CNT_W-1:0] r;
    r = '0;
    // Code zero means no debounce at all
    if (code == 5'h00) begin
      r = '0;
    end else if (code < SHORT_CODES) begin
      // Short codes double the step count
      r = CNT_W'(1) << (code - 5'h01);
    end else begin
      // Long codes count in 64 ms units
      r = CNT_W'(LONG_STEP_TICKS) * CNT_W'(code - LONG_BASE);
    end
    return r;
  endfunction : debounce_ticks

  // Byte address to register select
  function automatic agcdb_sel_type decode(
    input logic [ADDR_W-1:0] addr
  );
    agcdb_sel_type s;
    s = SEL_NONE;
    // Only aligned words in the low block decode
    if (addr[1:0] == 2'h0 && addr[ADDR_W-1:10] == '0) begin
      unique case (addr[9:2])
        IDX_LEFT_GAIN: s = SEL_LGAIN;
        IDX_RIGHT_GAIN: s = SEL_RGAIN;
        IDX_LEFT_DEB: s = SEL_LDEB;
        IDX_RIGHT_DEB: s = SEL_RDEB;
        IDX_CTRL: s = SEL_CTRL;
        IDX_FLAGS: s = SEL_FLAGS;
        IDX_IRQ_STAT: s = SEL_ISTAT;
        IDX_IRQ_MASK: s = SEL_IMASK;
        // Unlisted index, no register
        default: s = SEL_NONE;
      endcase
    end
    return s;
  endfunction : decode

  // Software visible state
  logic [7:0] deb_reg [2]; // Debounce settings per channel
  logic [7:0] deb_next [2];
  logic [7:0] ctrl_reg; // Control, bit 0 double rate audio
  logic [7:0] ctrl_next;
  logic [IRQ_W-1:0] istat_reg; // Sticky event bits
  logic [IRQ_W-1:0] istat_next;
  logic [IRQ_W-1:0] imask_reg; // Interrupt enables
  logic [IRQ_W-1:0] imask_next;
  logic irq_reg; // Interrupt line
  logic irq_next;
  agcdb_apb_rsp_type rsp_reg; // Bus answer
  agcdb_apb_rsp_type rsp_next;

  // Step prescaler
  logic [PRE_W-1:0] pre_reg;
  logic [PRE_W-1:0] pre_next;
  logic tick_reg; // One cycle per debounce step
  logic tick_next;

  // Per channel state
  agcdb_chan_type chan [2];
  logic [7:0] gain_reg [2]; // Applied gain readback
  logic [7:0] gain_next [2];
  logic det_reg [2]; // One while below the noise threshold
  logic det_next [2];
  logic sat_reg [2]; // Saturation flag
  logic sat_next [2];
  logic [CNT_W-1:0] cnt_reg [2]; // Debounce persistence count
  logic [CNT_W-1:0] cnt_next [2];
  logic det_evt [2]; // Detection state changed
  logic sat_evt [2]; // Saturation reached

  // Bus decode helpers
  agcdb_sel_type sel;
  logic access;
  logic done;
  logic [7:0] flags;

  assign chan[0] = LEFT_CHAN_IN;
  assign chan[1] = RIGHT_CHAN_IN;

  // Outputs come straight from flip-flops
  assign APB_RSP_OUT = rsp_reg;
  assign IRQ_OUT = irq_reg;
  assign GATE_STATE_OUT = {det_reg[1], det_reg[0]};

  // Step length for the current rate mode
  always_comb begin
    // Keep counting, no tick by default
    pre_next = pre_reg + PRE_W'(1);
    tick_next = 1'b0;
    // R9 double rate timing
    if (ctrl_reg[CTRL_DBL_RATE_BIT]) begin
      if (pre_reg >= STEP_HALF - PRE_W'(1)) begin
        // Half step elapsed
        pre_next = '0;
        tick_next = 1'b1;
      end
    end else if (pre_reg >= STEP_FULL - PRE_W'(1)) begin
      // Full step elapsed
      pre_next = '0;
      tick_next = 1'b1;
    end
  end

  // Prescaler registers
  always_ff @(posedge CLK_SYS_IN) begin
    if (RST_IN) begin
      // Restart the step count
      pre_reg <= '0;
      tick_reg <= 1'b0;
    end else begin
      pre_reg <= pre_next;
      tick_reg <= tick_next;
    end
  end

  // Identical logic for left and right channel
  for (genvar ch = 0; ch < 2; ch++) begin : g_chan
    logic [4:0] code; // Debounce code for pending direction
    logic [CNT_W-1:0] need; // Steps the condition must persist
    logic [6:0] cap; // Maximum gain limited to top code

    // Next detection, saturation and gain state
    always_comb begin
      gain_next[ch] = chan[ch].gain;
      det_next[ch] = det_reg[ch];
      cnt_next[ch] = cnt_reg[ch];
      // R4 noise field going quiet, R6 signal field
      // R7 right noise field, R8 right signal field
      if (chan[ch].below_thr) begin
        code = deb_reg[ch][NOISE_MSB:NOISE_LSB];
      end else begin
        code = {2'b00, deb_reg[ch][SIG_MSB:SIG_LSB]};
      end
      // R5 long codes in 64 ms steps
      need = debounce_ticks(code);
      if (chan[ch].noise_thr == 5'h00) begin
        // R13 detection off, debounce ignored
        det_next[ch] = 1'b0;
        cnt_next[ch] = '0;
      end else if (chan[ch].below_thr == det_reg[ch]) begin
        // Condition matches state, restart persistence
        cnt_next[ch] = '0;
      end else if (need == '0 ||
                   (tick_reg && cnt_reg[ch] + CNT_W'(1) >= need)) begin
        // R14 change after full persistence
        // R11 one while below threshold
        det_next[ch] = chan[ch].below_thr;
        cnt_next[ch] = '0;
      end else if (tick_reg) begin
        // Count another step of persistence
        cnt_next[ch] = cnt_reg[ch] + CNT_W'(1);
      end
      // Codes above the top gain mean 59.5 dB
      // R12 saturated at the allowed maximum
      if (chan[ch].max_gain > GAIN_MAX_CODE) begin
        cap = GAIN_MAX_CODE;
      end else begin
        cap = chan[ch].max_gain;
      end
      sat_next[ch] = (chan[ch].gain == {1'b0, cap});
      // Events for the status register
      det_evt[ch] = det_next[ch] != det_reg[ch];
      sat_evt[ch] = sat_next[ch] & ~sat_reg[ch];
    end

    // Channel registers
    always_ff @(posedge CLK_SYS_IN) begin
      if (RST_IN) begin
        // R3 readback starts at 0 dB
        gain_reg[ch] <= GAIN_RST;
        det_reg[ch] <= 1'b0;
        sat_reg[ch] <= 1'b0;
        cnt_reg[ch] <= '0;
      end else begin
        // Follow the computed next state
        gain_reg[ch] <= gain_next[ch];
        det_reg[ch] <= det_next[ch];
        sat_reg[ch] <= sat_next[ch];
        cnt_reg[ch] <= cnt_next[ch];
      end
    end
  end

  // Flag register image
  always_comb begin
    // Unused flag bits read as zero
    flags = 8'h00;
    flags[FLAG_LDET] = det_reg[0];
    flags[FLAG_LSAT] = sat_reg[0];
    flags[FLAG_RDET] = det_reg[1];
    flags[FLAG_RSAT] = sat_reg[1];
  end

  // Bus phase and select
  assign sel = decode(APB_REQ_IN.paddr);
  assign access = APB_REQ_IN.psel & APB_REQ_IN.penable;
  assign done = access & rsp_reg.pready;

  // Bus answer, register writes and interrupt state
  always_comb begin
    rsp_next = '0;
    // Configuration holds unless written
    deb_next[0] = deb_reg[0];
    deb_next[1] = deb_reg[1];
    ctrl_next = ctrl_reg;
    imask_next = imask_reg;
    istat_next = istat_reg;
    // One wait state, then answer
    if (access && !rsp_reg.pready) begin
      rsp_next.pready = 1'b1;
      rsp_next.pslverr = (sel == SEL_NONE);
      // Read mux, upper bits read as zero
      unique case (sel)
        // R1 left applied gain
        SEL_LGAIN: rsp_next.prdata = {24'h000000, gain_reg[0]};
        // R2 right applied gain
        SEL_RGAIN: rsp_next.prdata = {24'h000000, gain_reg[1]};
        SEL_LDEB: rsp_next.prdata = {24'h000000, deb_reg[0]};
        SEL_RDEB: rsp_next.prdata = {24'h000000, deb_reg[1]};
        SEL_CTRL: rsp_next.prdata = {24'h000000, ctrl_reg};
        SEL_FLAGS: rsp_next.prdata = {24'h000000, flags};
        SEL_ISTAT: rsp_next.prdata = {28'h0000000, istat_reg};
        SEL_IMASK: rsp_next.prdata = {28'h0000000, imask_reg};
        SEL_NONE: rsp_next.prdata = 32'h00000000;
      endcase
    end
    // Writes take effect on the completing edge
    if (done && APB_REQ_IN.pwrite) begin
      unique case (sel)
        // R10 debounce settings writable
        SEL_LDEB: deb_next[0] = APB_REQ_IN.pwdata[7:0];
        SEL_RDEB: deb_next[1] = APB_REQ_IN.pwdata[7:0];
        // Only the rate bit is kept
        SEL_CTRL: ctrl_next = {7'h00, APB_REQ_IN.pwdata[CTRL_DBL_RATE_BIT]};
        // Mask enables each status bit
        SEL_IMASK: imask_next = APB_REQ_IN.pwdata[IRQ_W-1:0];
        // Write one to clear
        SEL_ISTAT: istat_next = istat_reg & ~APB_REQ_IN.pwdata[IRQ_W-1:0];
        // Read-only or unmapped, ignored
        default: ctrl_next = ctrl_reg;
      endcase
    end
    // New events win over a clear in the same cycle
    istat_next[IRQ_LDET] = istat_next[IRQ_LDET] | det_evt[0];
    istat_next[IRQ_RDET] = istat_next[IRQ_RDET] | det_evt[1];
    istat_next[IRQ_LSAT] = istat_next[IRQ_LSAT] | sat_evt[0];
    istat_next[IRQ_RSAT] = istat_next[IRQ_RSAT] | sat_evt[1];
    irq_next = |(istat_next & imask_next);
  end

  // Bus and configuration registers
  always_ff @(posedge CLK_SYS_IN) begin
    if (RST_IN) begin
      // R10 debounce codes reset to zero
      deb_reg[0] <= DEB_RST;
      deb_reg[1] <= DEB_RST;
      ctrl_reg <= CTRL_RST;
      imask_reg <= IRQ_RST;
      istat_reg <= IRQ_RST;
      irq_reg <= 1'b0;
      rsp_reg <= '0;
    end else begin
      // Load all next values
      deb_reg[0] <= deb_next[0];
      deb_reg[1] <= deb_next[1];
      ctrl_reg <= ctrl_next;
      imask_reg <= imask_next;
      istat_reg <= istat_next;
      irq_reg <= irq_next;
      rsp_reg <= rsp_next;
    end
  end

endmodule : agcdb_top
`default_nettype wire

// >>> test/agcdb_checker.sv
// Checker of bus timing, gate state and gain readback relations
`timescale 1ns/1ps
`default_nettype none
module agcdb_checker
  import agcdb_pkg::*;
(
  input wire logic CLK_SYS_IN,
  input wire logic RST_IN,
  input wire agcdb_pkg::agcdb_apb_req_type APB_REQ_IN,
  input wire agcdb_pkg::agcdb_chan_type LEFT_CHAN_IN,
  input wire agcdb_pkg::agcdb_chan_type RIGHT_CHAN_IN,
  input wire agcdb_pkg::agcdb_apb_rsp_type APB_RSP_OUT,
  input wire logic [1:0] GATE_STATE_OUT,
  input wire logic IRQ_OUT
);
  default clocking @(posedge CLK_SYS_IN); endclocking
  default disable iff (RST_IN);
  // Shorthands for the watched fields
  wire logic rdy = APB_RSP_OUT.pready;
  wire logic [31:0] rdat = APB_RSP_OUT.prdata;
  wire logic [11:0] ad = APB_REQ_IN.paddr;
  wire logic rdg = rdy && !APB_REQ_IN.pwrite;
  wire agcdb_chan_type lc = LEFT_CHAN_IN;
  wire agcdb_chan_type rc = RIGHT_CHAN_IN;
  AST_WAIT: assert property (
    APB_REQ_IN.psel && APB_REQ_IN.penable && !rdy |=> rdy)
    else $error("no answer one cycle after access");
  AST_PULSE: assert property (rdy |=> !rdy)
    else $error("pready held longer than one cycle");
  AST_UNALIGNED: assert property (
    rdy && ad[1:0] != 2'b00 |-> APB_RSP_OUT.pslverr && rdat == 32'h0)
    else $error("unaligned access not refused");
  AST_GAIN_L: assert property (
    rdg && ad == 12'h080 && $stable(lc.gain) && lc.gain == $past(lc.gain, 2)
    |-> rdat == {24'h0, lc.gain})
    else $error("left gain readback wrong");
  AST_GAIN_R: assert property (
    rdg && ad == 12'h084 && $stable(rc.gain) && rc.gain == $past(rc.gain, 2)
    |-> rdat == {24'h0, rc.gain})
    else $error("right gain readback wrong");
  AST_RISE_L: assert property (
    $rose(GATE_STATE_OUT[0]) |-> $past(lc.below_thr) && $past(lc.noise_thr) != 5'h00)
    else $error("left gate rose without cause");
  AST_RISE_R: assert property (
    $rose(GATE_STATE_OUT[1]) |-> $past(rc.below_thr) && $past(rc.noise_thr) != 5'h00)
    else $error("right gate rose without cause");
  AST_FALL_L: assert property (
    $fell(GATE_STATE_OUT[0]) |-> !$past(lc.below_thr) || $past(lc.noise_thr) == 5'h00)
    else $error("left gate fell without cause");
  AST_FALL_R: assert property (
    $fell(GATE_STATE_OUT[1]) |-> !$past(rc.below_thr) || $past(rc.noise_thr) == 5'h00)
    else $error("right gate fell without cause");
  AST_OFF_L: assert property (lc.noise_thr == 5'h00 |=> !GATE_STATE_OUT[0])
    else $error("left detection not disabled");
  AST_OFF_R: assert property (rc.noise_thr == 5'h00 |=> !GATE_STATE_OUT[1])
    else $error("right detection not disabled");
  // Main scenarios reached
  cover property (APB_RSP_OUT.pslverr);
  cover property ($rose(GATE_STATE_OUT[1]));
  cover property ($rose(IRQ_OUT));
endmodule : agcdb_checker
bind agcdb_top agcdb_checker u_chk (.CLK_SYS_IN(CLK_SYS_IN), .RST_IN(RST_IN),
  .APB_REQ_IN(APB_REQ_IN), .LEFT_CHAN_IN(LEFT_CHAN_IN),
  .RIGHT_CHAN_IN(RIGHT_CHAN_IN), .APB_RSP_OUT(APB_RSP_OUT),
  .GATE_STATE_OUT(GATE_STATE_OUT), .IRQ_OUT(IRQ_OUT));
`default_nettype wire

// >>> test/agcdb_bench.sv
// Self-checking bench of the gain and gate debounce bank
`timescale 1ns/1ps
`default_nettype none
module agcdb_bench;
  import agcdb_pkg::*;
  localparam int SP = 8; // Short debounce step
  // Noise code of each pass; last pass runs at double rate
  function automatic int nc(input int k);
    return k == 9 ? 30 : k == 10 ? 3 : k;
  endfunction : nc
  logic clk = 1'b0;
  logic rst = 1'b1;
  agcdb_apb_req_type req = '0;
  agcdb_apb_rsp_type rsp;
  agcdb_chan_type ch [2];
  logic [1:0] gate;
  logic irq;
  logic [31:0] seed = 32'h94700D03;
  logic [31:0] q; // Read data taken at completion
  logic e; // Error flag taken at completion
  logic [7:0] eg [2]; // Model of gain readbacks
  logic [7:0] ed [2]; // Model of debounce registers
  int failures = 0;
  int cmp_count = 0;
  int n, i, c, s;
  agcdb_top #(.STEP_CYCLES(SP)) uut (.CLK_SYS_IN(clk), .RST_IN(rst),
    .APB_REQ_IN(req), .LEFT_CHAN_IN(ch[0]), .RIGHT_CHAN_IN(ch[1]),
    .APB_RSP_OUT(rsp), .GATE_STATE_OUT(gate), .IRQ_OUT(irq));
  // Free-running clock, 50 ns period
  always #25 clk = ~clk;
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : lfsr
  // Debounce length in steps for a code
  function automatic int steps(input int k);
    return k == 0 ? 0 : k < 8 ? 1 << (k - 1) : 128 * (k - 7);
  endfunction : steps
  task automatic results();
    if (failures == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : results
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      $display("BAD %0t got %h expected %h", $time, got, exp);
      failures++;
    end
  endtask : chk
  // One APB transfer, held until pready is seen
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge clk);
    req.penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (rsp.pready !== 1'b1 && n < 20);
    if (rsp.pready !== 1'b1) begin
      $display("BAD %0t bus timeout", $time);
      failures++;
      results();
    end
    q = rsp.prdata;
    e = rsp.pslverr;
    req <= '0;
  endtask : apb
  task automatic rd(input logic [11:0] a, input logic [31:0] x, input logic xe);
    apb(1'b0, a, 32'h0);
    chk(q, x);
    chk(e, xe);
  endtask : rd
  // Wait, bounded, for a gate bit to reach a level
  task automatic gwait(input int k, input logic t, input int b);
    n = 0;
    while (gate[k] !== t && n <= b) begin
      @(negedge clk);
      n++;
    end
    chk(gate[k], t);
    if (gate[k] !== t) results();
  endtask : gwait
  // Main sequence
  initial begin
    ch[0] = '{gain: 8'h00, max_gain: 7'h77, noise_thr: 5'h01, below_thr: 1'b0};
    ch[1] = ch[0];
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    for (i = 0; i < 4; i++) rd(12'(12'h080 + 4 * i), 32'h0, 1'b0);
    // Random gains, debounce writes, read-only write ignored
    for (i = 0; i < 3; i++) begin
      seed = lfsr(seed);
      eg[0] = seed[7] ? 8'hE8 + 8'(seed[2:0]) : {2'b00, seed[5:0]};
      eg[1] = {2'b00, seed[13:8]};
      ed[0] = seed[23:16] & 8'hF7;
      ed[1] = seed[31:24] & 8'hF7;
      ch[0].gain <= eg[0];
      ch[1].gain <= eg[1];
      for (c = 0; c < 2; c++) apb(1'b1, 12'(12'h088 + 4 * c), {seed[31:8], ed[c]});
      apb(1'b1, 12'h080, 32'hFF);
      for (c = 0; c < 2; c++) begin
        rd(12'(12'h080 + 4 * c), {24'h0, eg[c]}, 1'b0);
        rd(12'(12'h088 + 4 * c), {24'h0, ed[c]}, 1'b0);
      end
    end
    rd(12'h090, 32'h0, 1'b1);
    rd(12'h081, 32'h0, 1'b1);
    // Saturation events, masking and clearing
    ch[0].gain <= 8'h00;
    ch[1].gain <= 8'h00;
    apb(1'b1, 12'h0C8, 32'hF);
    ch[0].gain <= 8'h77;
    ch[1].gain <= 8'h77;
    rd(12'h0C4, 32'h11, 1'b0);
    rd(12'h0C8, 32'hC, 1'b0);
    chk(irq, 1'b0);
    apb(1'b1, 12'h0CC, 32'h4);
    @(negedge clk);
    chk(irq, 1'b1);
    apb(1'b1, 12'h0C8, 32'h4);
    @(negedge clk);
    chk(irq, 1'b0);
    rd(12'h0C8, 32'h8, 1'b0);
    ch[0].gain <= 8'h00;
    ch[1].gain <= 8'h00;
    // Debounce lengths in both directions, both channels
    for (i = 0; i < 11; i++) begin
      c = i % 2;
      s = i == 10 ? SP / 2 : SP;
      if (i == 10) apb(1'b1, 12'h0C0, 32'h1);
      apb(1'b1, 12'(12'h088 + 4 * c), {24'h0, 5'(nc(i)), 3'(i % 8)});
      ch[c].below_thr <= 1'b1;
      gwait(c, 1'b1, steps(nc(i)) * s + 6);
      chk(n > (steps(nc(i)) - 1) * s, 1'b1);
      rd(12'h0C4, c ? 32'h2 : 32'h20, 1'b0);
      ch[c].below_thr <= 1'b0;
      gwait(c, 1'b0, steps(i % 8) * s + 6);
      chk(n > (steps(i % 8) - 1) * s, 1'b1);
    end
    // Zero threshold keeps detection off
    @(posedge clk);
    ch[0].noise_thr <= 5'h00;
    ch[1].noise_thr <= 5'h00;
    ch[0].below_thr <= 1'b1;
    repeat (40) @(negedge clk);
    chk(gate, 2'b00);
    results();
  end
endmodule : agcdb_bench
`default_nettype wire
